// *** tbdl_map.svh ***
// Address map, field positions, reset values and timing constants of the detect logic.
`ifndef TBDL_MAP_SVH
`define TBDL_MAP_SVH

// ----------------------------------------------------------------------------
// Byte addresses in the configuration memory
// ----------------------------------------------------------------------------
`define TBDL_ADDR_POS_STAT   8'h05
`define TBDL_ADDR_NEG_STAT   8'h06
`define TBDL_ADDR_SIG_LO     8'h07
`define TBDL_ADDR_SIG_HI     8'h08
`define TBDL_ADDR_REF_LO     8'h09
`define TBDL_ADDR_REF_HI     8'h0a
`define TBDL_ADDR_DI         8'h0b
`define TBDL_ADDR_DRIFT      8'h16
`define TBDL_ADDR_INTEG      8'h17
`define TBDL_ADDR_RECAL      8'h18
`define TBDL_ADDR_HYST       8'h19
`define TBDL_ADDR_THR        8'h1b

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define TBDL_POS_DRIFT_INDEX_F        7:5
`define TBDL_BURST_F         4:3
`define TBDL_NEG_DRIFT_INDEX_F        2:0
`define TBDL_POS_NIB_F       7:4
`define TBDL_NEG_NIB_F       3:0
`define TBDL_POS_HYSTERESIS_INDEX_F         7:6
`define TBDL_NEG_HYSTERESIS_INDEX_F         5:4

// ----------------------------------------------------------------------------
// Reset values of the configuration bytes
// ----------------------------------------------------------------------------
`define TBDL_RST_DRIFT       8'h84
`define TBDL_RST_INTEG       8'h22
`define TBDL_RST_RECAL       8'h88
`define TBDL_RST_HYST        8'h50
`define TBDL_RST_THR         8'h44

// ----------------------------------------------------------------------------
// Timing: one tick is 100 ms of the 25 MHz clock
// ----------------------------------------------------------------------------
`define TBDL_CLK_HZ          25000000
`define TBDL_TICK_MS         100
`define TBDL_TICKS_PER_S     10
`define TBDL_HYST_SHIFT_MAX  3'h4

`endif

// *** tbdl_pkg.sv ***
// Types shared by the touch baseline detect logic.
package tbdl_pkg;

  // Detect state, Gray coded along track, positive, recalibrate, negative.
  typedef enum logic [1:0] {
    TBDL_TRACK = 2'b00,
    TBDL_POS   = 2'b01,
    TBDL_RECAL = 2'b11,
    TBDL_NEG   = 2'b10
  } tbdl_state_t;

endpackage

// *** tbdl_lut.sv ***
// Lookup tables that turn configuration indices into levels and tick counts.
`timescale 1ns/1ps
`include "tbdl_map.svh"

module tbdl_lut
  import tbdl_pkg::*;
(
  // Indices.
  input  wire logic [3:0]  thr_index,
  input  wire logic [3:0]  limit_index,
  input  wire logic [3:0]  recal_index,
  input  wire logic [2:0]  drift_index,
  input  wire logic [1:0]  hyst_index,
  // Decoded values.
  output logic      [7:0]  threshold,
  output logic      [7:0]  integ_limit,
  output logic      [11:0] recal_ticks,
  output logic      [6:0]  drift_ticks,
  output logic      [2:0]  hyst_shift
);

  // Shared table of integrator limits and recalibration seconds.
  function automatic logic [7:0] seq_lut(input logic [3:0] idx);
    case (idx)
      4'h0:    seq_lut = 8'd2;
      4'h1:    seq_lut = 8'd3;
      4'h2:    seq_lut = 8'd5;
      4'h3:    seq_lut = 8'd7;
      4'h4:    seq_lut = 8'd9;
      4'h5:    seq_lut = 8'd12;
      4'h6:    seq_lut = 8'd15;
      4'h7:    seq_lut = 8'd20;
      4'h8:    seq_lut = 8'd32;
      4'h9:    seq_lut = 8'd45;
      4'ha:    seq_lut = 8'd60;
      4'hb:    seq_lut = 8'd90;
      4'hc:    seq_lut = 8'd123;
      4'hd:    seq_lut = 8'd150;
      4'he:    seq_lut = 8'd190;
      default: seq_lut = 8'd254;
    endcase
  endfunction

  // Threshold counts.
  function automatic logic [7:0] thr_lut(input logic [3:0] idx);
    case (idx)
      4'h0:    thr_lut = 8'd10;
      4'h1:    thr_lut = 8'd12;
      4'h2:    thr_lut = 8'd16;
      4'h3:    thr_lut = 8'd22;
      4'h4:    thr_lut = 8'd30;
      4'h5:    thr_lut = 8'd40;
      4'h6:    thr_lut = 8'd52;
      4'h7:    thr_lut = 8'd66;
      4'h8:    thr_lut = 8'd82;
      4'h9:    thr_lut = 8'd100;
      4'ha:    thr_lut = 8'd120;
      4'hb:    thr_lut = 8'd142;
      4'hc:    thr_lut = 8'd166;
      4'hd:    thr_lut = 8'd192;
      4'he:    thr_lut = 8'd220;
      default: thr_lut = 8'd254;
    endcase
  endfunction

  // Drift intervals in 100 ms ticks: 0.2 s up to 10 s.
  function automatic logic [6:0] drift_lut(input logic [2:0] idx);
    case (idx)
      3'h0:    drift_lut = 7'd2;
      3'h1:    drift_lut = 7'd4;
      3'h2:    drift_lut = 7'd8;
      3'h3:    drift_lut = 7'd12;
      3'h4:    drift_lut = 7'd20;
      3'h5:    drift_lut = 7'd33;
      3'h6:    drift_lut = 7'd60;
      default: drift_lut = 7'd100;
    endcase
  endfunction

  // Decoded outputs; recalibration seconds scale to ticks.
  assign threshold   = thr_lut(thr_index);                               // see [R19]
  assign integ_limit = seq_lut(limit_index);                             // see [R11]
  assign recal_ticks = 12'(seq_lut(recal_index) * `TBDL_TICKS_PER_S);    // see [R17]
  assign drift_ticks = drift_lut(drift_index);                           // see [R5]
  assign hyst_shift  = `TBDL_HYST_SHIFT_MAX - {1'b0, hyst_index};        // see [R20]

endmodule // tbdl_lut

// *** tbdl_detect.sv ***
// Touch baseline detect logic: drift tracking, detect integrator and recalibration timeout.
//
// Behaviour
// [R1] Reference creeps toward the signal slowly, slew limited.
// [R2] Tracking pauses during detect or threshold crossing; resumes between thresholds.
// [R3] Thresholds and hysteresis levels are computed from the current reference.
// [R4] Upward and downward drift use separate interval settings.
// [R5] Drift index 0..7 maps to 0.2 to 10 seconds.
// [R6] Byte 22: positive drift bits 7..5, burst 4..3, negative drift 2..0.
// [R7] Each sample is tested against thresholds and counted in the integrator.
// [R8] Detect is declared only when the integrator reaches its limit.
// [R9] Signal above reference plus positive threshold counts toward positive limit.
// [R10] Signal below reference minus negative threshold counts toward negative limit.
// [R11] Integrator index 0..15 maps to limits 2 through 254.
// [R12] Byte 23: positive integrator index high nibble, negative low nibble.
// [R13] Detect lasting past the recalibration delay is cancelled and reference reset.
// [R14] After recalibration, normal detection resumes from the new reference.
// [R15] Positive detect uses positive delay; negative detect uses negative delay.
// [R16] The recalibration timeout always runs and cannot be disabled.
// [R17] Recalibration index 0..15 maps to 2 through 254 seconds.
// [R18] Byte 24: positive recalibration index high nibble, negative low nibble.
// [R19] Threshold index decodes through a sixteen-entry table, 10 to 254.
// [R20] Declared detect drops out at hysteresis point 6.25 to 50 percent.
// [R21] Integrator clears when a sample returns inside both thresholds before detect.
// [R22] Reference moves one count each elapsed drift interval without crossing.
`timescale 1ns/1ps
`include "tbdl_map.svh"

module tbdl_detect
  import tbdl_pkg::*;
#(
  parameter int TICK_CYCLES = `TBDL_CLK_HZ / 1000 * `TBDL_TICK_MS
)
(
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // Samples from the acquisition front end.
  input  wire logic        sample_valid,
  input  wire logic [15:0] sample_data,
  // Configuration memory port.
  input  wire logic        cfg_wr_en,
  input  wire logic        cfg_rd_en,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [7:0]  cfg_wr_data,
  output logic      [7:0]  cfg_rd_data,
  // Detect results.
  output logic             pos_detect,
  output logic             neg_detect,
  output logic             recal_event,
  output logic      [15:0] reference_level,
  output logic      [7:0]  detection_integrator_counter,
  output logic      [1:0]  burst_length_index
);

  // --------------------------------------------------------------------------
  // Configuration bytes
  // --------------------------------------------------------------------------
  localparam logic [21:0] TICK_LAST = 22'(TICK_CYCLES - 1);

  logic [7:0] drift_cfg_reg, drift_cfg_next;
  logic [7:0] integ_cfg_reg, integ_cfg_next;
  logic [7:0] recal_cfg_reg, recal_cfg_next;
  logic [7:0] hyst_cfg_reg,  hyst_cfg_next;
  logic [7:0] thr_cfg_reg,   thr_cfg_next;

  // Writes land only on the configuration bytes; status bytes ignore writes.
  always_comb begin
    drift_cfg_next = drift_cfg_reg;
    integ_cfg_next = integ_cfg_reg;
    recal_cfg_next = recal_cfg_reg;
    hyst_cfg_next  = hyst_cfg_reg;
    thr_cfg_next   = thr_cfg_reg;
    if (cfg_wr_en) begin
      case (cfg_addr)
        `TBDL_ADDR_DRIFT: drift_cfg_next = cfg_wr_data;
        `TBDL_ADDR_INTEG: integ_cfg_next = cfg_wr_data;
        `TBDL_ADDR_RECAL: recal_cfg_next = cfg_wr_data;
        `TBDL_ADDR_HYST:  hyst_cfg_next  = cfg_wr_data;
        `TBDL_ADDR_THR:   thr_cfg_next   = cfg_wr_data;
        default:          drift_cfg_next = drift_cfg_reg;
      endcase
    end
  end

  // Registers the configuration bytes.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      drift_cfg_reg <= `TBDL_RST_DRIFT;
      integ_cfg_reg <= `TBDL_RST_INTEG;
      recal_cfg_reg <= `TBDL_RST_RECAL;
      hyst_cfg_reg  <= `TBDL_RST_HYST;
      thr_cfg_reg   <= `TBDL_RST_THR;
    end else begin
      drift_cfg_reg <= drift_cfg_next;
      integ_cfg_reg <= integ_cfg_next;
      recal_cfg_reg <= recal_cfg_next;
      hyst_cfg_reg  <= hyst_cfg_next;
      thr_cfg_reg   <= thr_cfg_next;
    end
  end

  assign burst_length_index = drift_cfg_reg[`TBDL_BURST_F];

  // --------------------------------------------------------------------------
  // Index decoding, one table set per direction
  // --------------------------------------------------------------------------
  logic [7:0]  pos_thr,   neg_thr;
  logic [7:0]  pos_limit, neg_limit;
  logic [11:0] pos_recal, neg_recal;
  logic [6:0]  pos_drift, neg_drift;
  logic [2:0]  pos_shift, neg_shift;

  // Positive direction tables.
  tbdl_lut u_pos_lut (
    .thr_index   (thr_cfg_reg[`TBDL_POS_NIB_F]),
    .limit_index (integ_cfg_reg[`TBDL_POS_NIB_F]),  // see [R12]
    .recal_index (recal_cfg_reg[`TBDL_POS_NIB_F]),  // see [R18]
    .drift_index (drift_cfg_reg[`TBDL_POS_DRIFT_INDEX_F]),   // see [R6]
    .hyst_index  (hyst_cfg_reg[`TBDL_POS_HYSTERESIS_INDEX_F]),
    .threshold   (pos_thr),
    .integ_limit (pos_limit),
    .recal_ticks (pos_recal),
    .drift_ticks (pos_drift),
    .hyst_shift  (pos_shift)
  );

  // Negative direction tables.
  tbdl_lut u_neg_lut (
    .thr_index   (thr_cfg_reg[`TBDL_NEG_NIB_F]),
    .limit_index (integ_cfg_reg[`TBDL_NEG_NIB_F]),  // see [R12]
    .recal_index (recal_cfg_reg[`TBDL_NEG_NIB_F]),  // see [R18]
    .drift_index (drift_cfg_reg[`TBDL_NEG_DRIFT_INDEX_F]),   // see [R6]
    .hyst_index  (hyst_cfg_reg[`TBDL_NEG_HYSTERESIS_INDEX_F]),
    .threshold   (neg_thr),
    .integ_limit (neg_limit),
    .recal_ticks (neg_recal),
    .drift_ticks (neg_drift),
    .hyst_shift  (neg_shift)
  );

  // --------------------------------------------------------------------------
  // 100 ms time base
  // --------------------------------------------------------------------------
  logic [21:0] presc_reg, presc_next;
  logic        tick_reg,  tick_next;

  // Counts clock cycles and emits a one-cycle tick every 100 ms.
  always_comb begin
    tick_next  = (presc_reg == TICK_LAST);
    presc_next = tick_next ? '0 : presc_reg + 22'h000001;
  end

  // Registers the time base.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      presc_reg <= '0;
      tick_reg  <= 1'b0;
    end else begin
      presc_reg <= presc_next;
      tick_reg  <= tick_next;
    end
  end

  // --------------------------------------------------------------------------
  // Level comparisons against the current reference
  // --------------------------------------------------------------------------
  tbdl_state_t state_reg, state_next;
  logic [15:0] ref_reg,   ref_next;
  logic [15:0] sig_reg,   sig_next;
  logic [7:0]  di_reg,    di_next;
  logic        di_pos_reg, di_pos_next;
  logic        inside_reg, inside_next;
  logic [6:0]  drift_cnt_reg, drift_cnt_next;
  logic [11:0] recal_cnt_reg, recal_cnt_next;
  logic        recal_evt_reg, recal_evt_next;

  logic [16:0] pos_level;
  logic [16:0] neg_sum;
  logic [7:0]  pos_hyst;
  logic [7:0]  neg_hyst;
  logic        above;
  logic        below;
  logic        pos_release;
  logic        neg_release;
  logic [6:0]  drift_target;

  // Thresholds and drop-out points ride on the reference.
  always_comb begin
    pos_level    = {1'b0, ref_reg} + {9'h000, pos_thr};                   // see [R3]
    neg_sum      = {1'b0, sample_data} + {9'h000, neg_thr};
    pos_hyst     = pos_thr >> pos_shift;                                  // see [R20]
    neg_hyst     = neg_thr >> neg_shift;                                  // see [R20]
    above        = {1'b0, sample_data} > pos_level;                       // see [R9]
    below        = neg_sum < {1'b0, ref_reg};                             // see [R10]
    pos_release  = {1'b0, sample_data} < (pos_level - {9'h000, pos_hyst});
    neg_release  = neg_sum > ({1'b0, ref_reg} + {9'h000, neg_hyst});
    drift_target = (sig_reg > ref_reg) ? pos_drift : neg_drift;           // see [R4]
  end

  // --------------------------------------------------------------------------
  // Detect state machine
  // --------------------------------------------------------------------------
  // Sample evaluation, integrator, drift and recalibration timeout.
  always_comb begin
    state_next     = state_reg;
    ref_next       = ref_reg;
    sig_next       = sig_reg;
    di_next        = di_reg;
    di_pos_next    = di_pos_reg;
    inside_next    = inside_reg;
    drift_cnt_next = drift_cnt_reg;
    recal_cnt_next = recal_cnt_reg;
    recal_evt_next = 1'b0;
    case (state_reg)
      TBDL_TRACK: begin
        recal_cnt_next = '0;
        if (sample_valid) begin
          sig_next    = sample_data;
          inside_next = !above && !below;                                 // see [R7]
          if (above) begin
            di_next     = (di_pos_reg && di_reg != 8'h00) ? di_reg + 8'h01 : 8'h01;
            di_pos_next = 1'b1;
            if (di_next >= pos_limit) begin
              state_next = TBDL_POS;                                      // see [R8]
            end
          end else if (below) begin
            di_next     = (!di_pos_reg && di_reg != 8'h00) ? di_reg + 8'h01 : 8'h01;
            di_pos_next = 1'b0;
            if (di_next >= neg_limit) begin
              state_next = TBDL_NEG;                                      // see [R8]
            end
          end else begin
            di_next = 8'h00;                                              // see [R21]
          end
          if (above || below) begin
            drift_cnt_next = '0;                                          // see [R2]
          end
        end else if (tick_reg && inside_reg) begin
          // One count per elapsed interval keeps the slew slow.
          if (drift_cnt_reg + 7'h01 >= drift_target) begin
            drift_cnt_next = '0;
            if (sig_reg > ref_reg) begin
              ref_next = ref_reg + 16'h0001;                              // see [R1], [R22]
            end else if (sig_reg < ref_reg) begin
              ref_next = ref_reg - 16'h0001;                              // see [R1], [R22]
            end
          end else begin
            drift_cnt_next = drift_cnt_reg + 7'h01;
          end
        end
      end
      TBDL_POS, TBDL_NEG: begin
        drift_cnt_next = '0;                                              // see [R2]
        if (sample_valid) begin
          sig_next = sample_data;
          if ((state_reg == TBDL_POS) ? pos_release : neg_release) begin
            state_next  = TBDL_TRACK;                                     // see [R20]
            di_next     = 8'h00;
            inside_next = 1'b0;
          end
        end
        // The timeout has no off setting, so every detect is bounded.
        if (state_next != TBDL_TRACK && tick_reg) begin                   // see [R16]
          recal_cnt_next = recal_cnt_reg + 12'h001;
          if (recal_cnt_next >= ((state_reg == TBDL_POS) ? pos_recal : neg_recal)) begin
            state_next = TBDL_RECAL;                                      // see [R13], [R15]
          end
        end
      end
      TBDL_RECAL: begin
        // Re-baseline on the present signal and go back to tracking.
        ref_next       = sig_reg;                                         // see [R13]
        di_next        = 8'h00;
        inside_next    = 1'b0;
        recal_cnt_next = '0;
        recal_evt_next = 1'b1;
        state_next     = TBDL_TRACK;                                      // see [R14]
      end
      default: begin
        state_next = TBDL_TRACK;
      end
    endcase
  end

  // Registers the detect state.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg     <= TBDL_TRACK;
      ref_reg       <= '0;
      sig_reg       <= '0;
      di_reg        <= '0;
      di_pos_reg    <= 1'b0;
      inside_reg    <= 1'b0;
      drift_cnt_reg <= '0;
      recal_cnt_reg <= '0;
      recal_evt_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      ref_reg       <= ref_next;
      sig_reg       <= sig_next;
      di_reg        <= di_next;
      di_pos_reg    <= di_pos_next;
      inside_reg    <= inside_next;
      drift_cnt_reg <= drift_cnt_next;
      recal_cnt_reg <= recal_cnt_next;
      recal_evt_reg <= recal_evt_next;
    end
  end

  // Detect outputs straight from state flops.
  assign pos_detect                   = (state_reg == TBDL_POS);
  assign neg_detect                   = (state_reg == TBDL_NEG);
  assign recal_event                  = recal_evt_reg;
  assign reference_level              = ref_reg;
  assign detection_integrator_counter = di_reg;

  // --------------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------------
  logic [7:0] rd_data_reg, rd_data_next;

  // Selects the addressed byte; multi-byte values are little endian.
  always_comb begin
    rd_data_next = rd_data_reg;
    if (cfg_rd_en) begin
      case (cfg_addr)
        `TBDL_ADDR_POS_STAT: rd_data_next = {7'h00, pos_detect};
        `TBDL_ADDR_NEG_STAT: rd_data_next = {7'h00, neg_detect};
        `TBDL_ADDR_SIG_LO:   rd_data_next = sig_reg[7:0];
        `TBDL_ADDR_SIG_HI:   rd_data_next = sig_reg[15:8];
        `TBDL_ADDR_REF_LO:   rd_data_next = ref_reg[7:0];
        `TBDL_ADDR_REF_HI:   rd_data_next = ref_reg[15:8];
        `TBDL_ADDR_DI:       rd_data_next = di_reg;
        `TBDL_ADDR_DRIFT:    rd_data_next = drift_cfg_reg;
        `TBDL_ADDR_INTEG:    rd_data_next = integ_cfg_reg;
        `TBDL_ADDR_RECAL:    rd_data_next = recal_cfg_reg;
        `TBDL_ADDR_HYST:     rd_data_next = hyst_cfg_reg;
        `TBDL_ADDR_THR:      rd_data_next = thr_cfg_reg;
        default:             rd_data_next = 8'h00;
      endcase
    end
  end

  // Registers the read data.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data_reg <= 8'h00;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign cfg_rd_data = rd_data_reg;

endmodule // tbdl_detect

// *** tbdl_detect_assertions.sv ***
// Concurrent checks on the ports of the touch baseline detect logic.
`timescale 1ns/1ps
`include "tbdl_map.svh"

module tbdl_detect_chk (
  // Clock and reset.
  input wire logic        mclk,
  input wire logic        sys_rst,
  // Inputs of the detect logic.
  input wire logic        sample_valid,
  input wire logic [15:0] sample_data,
  input wire logic        cfg_rd_en,
  input wire logic [7:0]  cfg_addr,
  // Outputs of the detect logic.
  input wire logic [7:0]  cfg_rd_data,
  input wire logic        pos_detect,
  input wire logic        neg_detect,
  input wire logic        recal_event,
  input wire logic [15:0] reference_level,
  input wire logic [7:0]  detection_integrator_counter
);
  logic [15:0] last_reg;
  logic [15:0] last_next;

  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // Keeps the most recent sample, which a recalibration must adopt.
  always_comb begin
    last_next = sample_valid ? sample_data : last_reg;
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      last_reg <= 16'h0;
    end else begin
      last_reg <= last_next;
    end
  end

  a_detect_exclusive: assert property (!(pos_detect && neg_detect))
    else $error("Both detect outputs are high.");
  a_detect_count: assert property ($rose(pos_detect) || $rose(neg_detect)
    |-> detection_integrator_counter >= 8'h02) else $error("Detect before count.");
  a_count_step: assert property (detection_integrator_counter >
    $past(detection_integrator_counter) |-> $past(sample_valid) &&
    detection_integrator_counter == $past(detection_integrator_counter) + 8'h01)
    else $error("Integrator rose without a sample or by more than one.");
  a_ref_frozen: assert property ((pos_detect || neg_detect) &&
    $past(pos_detect || neg_detect) |-> $stable(reference_level))
    else $error("Reference moved during a detect.");
  a_ref_slew: assert property (!recal_event |->
    (reference_level - $past(reference_level)) inside {16'h0, 16'h1, 16'hffff})
    else $error("Reference stepped by more than one count.");
  a_recal_cancel: assert property (recal_event |->
    $past(pos_detect || neg_detect, 2) && !pos_detect && !neg_detect)
    else $error("Recalibration without a cancelled detect.");
  a_recal_ref: assert property (recal_event |-> reference_level == last_reg)
    else $error("Reference not set to the last sample.");
  a_stat_read: assert property ($past(cfg_rd_en) && $past(cfg_addr) == `TBDL_ADDR_POS_STAT
    |-> cfg_rd_data == {7'h0, $past(pos_detect)}) else $error("Bad status read.");
endmodule // tbdl_detect_chk

bind tbdl_detect tbdl_detect_chk u_chk (.mclk(mclk), .sys_rst(sys_rst),
  .sample_valid(sample_valid), .sample_data(sample_data), .cfg_rd_en(cfg_rd_en),
  .cfg_addr(cfg_addr), .cfg_rd_data(cfg_rd_data), .pos_detect(pos_detect),
  .neg_detect(neg_detect), .recal_event(recal_event), .reference_level(reference_level),
  .detection_integrator_counter(detection_integrator_counter));

// *** tbdl_sample_src.sv ***
// Model of the acquisition front end that delivers periodic samples.
`timescale 1ns/1ps

module tbdl_sample_src (
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // Commanded level and sample spacing; a zero spacing stops sampling.
  input  wire logic [15:0] level,
  input  wire logic [7:0]  gap,
  // Samples to the detect logic.
  output logic             sample_valid,
  output logic      [15:0] sample_data
);
  int cnt = 0;

  initial begin
    sample_valid = 1'b0;
    sample_data  = 16'h0;
  end

  // One-cycle pulses; between them the data inverts every cycle, so it alternates with the sampled value.
  always @(posedge mclk) begin
    #1;
    sample_valid = 1'b0;
    sample_data  = ~sample_data;
    cnt++;
    if (!sys_rst && gap != 8'h0 && cnt >= gap) begin
      cnt          = 0;
      sample_valid = 1'b1;
      sample_data  = level;
    end
  end
endmodule // tbdl_sample_src

// *** tbdl_detect_test.sv ***
// Self-checking testbench for the touch baseline detect logic.
`timescale 1ns/1ps

`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
`define WAIT(c, n) begin waited = 0; while (!(c) && waited < (n)) begin \
  cyc(1); waited++; end `CHK((c), 1'b1) end

module tbdl_detect_test;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        sample_valid;
  logic [15:0] sample_data;
  logic        cfg_wr_en = 1'b0;
  logic        cfg_rd_en = 1'b0;
  logic [7:0]  cfg_addr = 8'h0;
  logic [7:0]  cfg_wr_data = 8'h0;
  logic [7:0]  cfg_rd_data;
  logic        pos_detect;
  logic        neg_detect;
  logic        recal_event;
  logic [15:0] reference_level;
  logic [7:0]  detection_integrator_counter;
  logic [1:0]  burst_length_index;
  logic [15:0] level = 16'h0;
  logic [7:0]  gap = 8'h0;
  logic [15:0] r;
  logic [7:0]  d;
  int          waited;
  int          bad_count = 0;
  int          cmp_count = 0;

  always #20 mclk = ~mclk;

  tbdl_sample_src src (.mclk(mclk), .sys_rst(sys_rst), .level(level), .gap(gap),
    .sample_valid(sample_valid), .sample_data(sample_data));
  tbdl_detect #(.TICK_CYCLES(10)) uut (.mclk(mclk), .sys_rst(sys_rst),
    .sample_valid(sample_valid), .sample_data(sample_data), .cfg_wr_en(cfg_wr_en),
    .cfg_rd_en(cfg_rd_en), .cfg_addr(cfg_addr), .cfg_wr_data(cfg_wr_data),
    .cfg_rd_data(cfg_rd_data), .pos_detect(pos_detect), .neg_detect(neg_detect),
    .recal_event(recal_event), .reference_level(reference_level),
    .detection_integrator_counter(detection_integrator_counter),
    .burst_length_index(burst_length_index));

  // Waits edges, then steps just past the last one.
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Byte write and byte read on the configuration port.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    cfg_wr_en   = 1'b1;
    cfg_addr    = a;
    cfg_wr_data = v;
    cyc(1);
    cfg_wr_en = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a);
    cfg_rd_en = 1'b1;
    cfg_addr  = a;
    cyc(1);
    cfg_rd_en = 1'b0;
    d = cfg_rd_data;
    cyc(1);
  endtask

  // Reset values and a refused write to the integrator location.
  task automatic t_reset;
    rd(8'h16);
    `CHK(d, 8'h84)
    rd(8'h17);
    `CHK(d, 8'h22)
    rd(8'h18);
    `CHK(d, 8'h88)
    wr(8'h0b, 8'hff);
    rd(8'h0b);
    `CHK(d, 8'h00)
  endtask

  // Positive detect after five samples, then timeout with the 2 s positive delay.
  task automatic t_pos;
    wr(8'h18, 8'h08);
    level = 16'd100;
    gap   = 8'h4;
    `WAIT(pos_detect, 200)
    `CHK(detection_integrator_counter, 8'h05)
    `CHK(reference_level, 16'h0)
    rd(8'h05);
    `CHK(d, 8'h01)
    `WAIT(recal_event, 400)
    `CHK(waited >= 185 && waited <= 215, 1'b1)
    `CHK(reference_level, 16'd100)
    cyc(12);
    `CHK(pos_detect, 1'b0)
    `CHK(detection_integrator_counter, 8'h00)
  endtask

  // Negative detect at limit 2, held at the hysteresis point, released one past it.
  task automatic t_neg;
    wr(8'h17, 8'h20);
    level = 16'd50;
    `WAIT(neg_detect, 100)
    `CHK(detection_integrator_counter, 8'h02)
    level = 16'd73;
    cyc(20);
    `CHK(neg_detect, 1'b1)
    `CHK(reference_level, 16'd100)
    rd(8'h06);
    `CHK(d, 8'h01)
    level = 16'd74;
    `WAIT(!neg_detect, 20)
    cyc(2);
    `CHK(detection_integrator_counter, 8'h00)
  endtask

  // Two crossings of a lowered threshold, then an inside sample clears the integrator.
  task automatic t_clear;
    wr(8'h1b, 8'h34);
    level = 16'd125;
    `WAIT(detection_integrator_counter == 8'h02, 40)
    level = 16'd100;
    cyc(9);
    `CHK(detection_integrator_counter, 8'h00)
    `CHK(pos_detect, 1'b0)
  endtask

  // Fast upward drift, then slow upward and fast downward settings.
  task automatic t_drift;
    wr(8'h16, 8'h18);
    `CHK(burst_length_index, 2'h3)
    level = 16'd110;
    gap   = 8'h7;
    r     = reference_level;
    `WAIT(reference_level !== r, 100)
    `CHK(reference_level, r + 16'h1)
    wr(8'h16, 8'he0);
    level = 16'd90;
    r     = reference_level;
    `WAIT(reference_level !== r, 100)
    `CHK(reference_level, r - 16'h1)
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Main sequence after twenty cycles of reset.
  initial begin
    cyc(20);
    sys_rst = 1'b0;
    t_reset();
    t_pos();
    t_neg();
    t_clear();
    t_drift();
    conclude();
  end

  // Cuts a hang short well beyond the expected run of about 400 cycles.
  initial begin
    #800000;
    bad_count++;
    conclude();
  end
endmodule // tbdl_detect_test
